// [verilog/spw_consts.svh]
`ifndef SPW_CONSTS_SVH
`define SPW_CONSTS_SVH

`define SPW_CLK_PERIOD_NS 4
`define SPW_CNT_W 8
`define SPW_NCH 4
`define SPW_PER_RESET 8'hff
`define SPW_CNT_RESET 8'h00
`define SPW_CMP_RESET 8'h00
`define SPW_ZERO 8'h00
`define SPW_PSC_W 10
`define SPW_PSC_RESET 10'h000
`define SPW_PSC_ONE 10'h001
`define SPW_SEL_OFF 4'h0
`define SPW_SEL_DIV1 4'h1
`define SPW_SEL_DIV2 4'h2
`define SPW_SEL_DIV4 4'h3
`define SPW_SEL_DIV8 4'h4
`define SPW_SEL_DIV64 4'h5
`define SPW_SEL_DIV256 4'h6
`define SPW_SEL_DIV1024 4'h7
`define SPW_SEL_EVT 4'h8
`define SPW_EVT_W 3
`define SPW_TAP_DIV2 0
`define SPW_TAP_DIV4 1
`define SPW_TAP_DIV8 2
`define SPW_TAP_DIV64 5
`define SPW_TAP_DIV256 7
`define SPW_TAP_DIV1024 9
`define SPW_HIRES_W 2
`define SPW_HIRES_OFF 2'h0

`endif

// [verilog/spw_pkg.sv]
`include "spw_consts.svh"

package spw_pkg;
  typedef logic [`SPW_CNT_W-1:0] spw_byte_t;
  typedef logic [`SPW_NCH-1:0] spw_nib_t;

  typedef enum logic [1:0] {
    SPW_NORMAL = 2'h1,
    SPW_SPLIT = 2'h2
  } spw_mode_e;

  // Setup for one eight-bit counter
  typedef struct packed {
    spw_byte_t per;
    spw_byte_t cmp_d;
    spw_byte_t cmp_c;
    spw_byte_t cmp_b;
    spw_byte_t cmp_a;
    spw_nib_t cmp_en;
  } spw_half_cfg_s;

  typedef struct packed {
    spw_byte_t cnt;
    spw_nib_t wave;
    spw_nib_t match;
    logic bottom;
  } spw_half_st_s;
endpackage

// [verilog/spw_half.sv]
`timescale 1ns/1ns
`default_nettype none
`include "spw_consts.svh"

module spw_half (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic run,
  input wire logic tick,
  input wire spw_pkg::spw_half_cfg_s cfg,
  output spw_pkg::spw_half_st_s st
);
  spw_pkg::spw_byte_t cnt_reg, cnt_next;
  spw_pkg::spw_nib_t wave_reg, wave_next;
  spw_pkg::spw_nib_t match;
  spw_pkg::spw_byte_t cmp [`SPW_NCH];

  always_comb begin
    cmp[0] = cfg.cmp_a;
    cmp[1] = cfg.cmp_b;
    cmp[2] = cfg.cmp_c;
    cmp[3] = cfg.cmp_d;
    for (int i = 0; i < `SPW_NCH; i++) begin
      match[i] = (cnt_reg == cmp[i]);
    end
  end

  always_comb begin
    cnt_next = cnt_reg;
    wave_next = wave_reg;
    if (!run) begin
      cnt_next = cnt_reg;
    end else if (tick) begin
      if (cnt_reg == `SPW_ZERO) begin
        cnt_next = cfg.per;
      end else begin
        cnt_next = cnt_reg - 8'h01;
      end
      for (int i = 0; i < `SPW_NCH; i++) begin
        // Clear at bottom wins so a zero compare gives a steady low
        if (cnt_reg == `SPW_ZERO) begin
          wave_next[i] = 1'b0;
        end else if (match[i]) begin
          wave_next[i] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= `SPW_CNT_RESET;
      wave_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
      wave_reg <= wave_next;
    end
  end

  assign st.cnt = cnt_reg;
  assign st.wave = wave_reg;
  assign st.match = match;
  assign st.bottom = (cnt_reg == `SPW_ZERO);
endmodule
`default_nettype wire

// [verilog/spw_timer.sv]
`timescale 1ns/1ns
`default_nettype none
`include "spw_consts.svh"

module spw_timer (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic split_mode,
  input wire logic [3:0] clk_sel,
  input wire logic [`SPW_EVT_W-1:0] evt_sel,
  input wire logic [(1<<`SPW_EVT_W)-1:0] evt_chan,
  input wire logic [`SPW_HIRES_W-1:0] hires_sel,
  input wire spw_pkg::spw_half_cfg_s low_cfg,
  input wire spw_pkg::spw_half_cfg_s high_cfg,
  input wire logic [7:0] port_out,
  input wire logic [7:0] port_inv,
  input wire logic [3:0] cmp_ack,
  output logic [7:0] pin_out,
  output logic [7:0] waveform_output,
  output logic [3:0] cmp_flag,
  output logic [3:0] cmp_event,
  output logic [3:0] cmp_dma_req,
  output logic low_unf_event,
  output logic high_unf_event,
  output logic [7:0] low_cnt,
  output logic [7:0] high_cnt,
  output logic [`SPW_HIRES_W-1:0] hires_phase,
  output logic running
);
  typedef enum logic [1:0] {
    SPW_ST_OFF = 2'b01,
    SPW_ST_RUN = 2'b10
  } spw_run_e;

  spw_run_e run_reg, run_next;
  logic [`SPW_PSC_W-1:0] psc_reg, psc_next;
  logic tick;
  logic run;
  logic [3:0] flag_reg, flag_next;
  logic [3:0] evt_reg, evt_next;
  logic [1:0] unf_reg, unf_next;
  logic [7:0] pin_reg, pin_next;
  logic [`SPW_HIRES_W-1:0] hr_reg, hr_next;
  spw_pkg::spw_half_st_s low_st, high_st;

  function automatic logic psc_tap(input logic [`SPW_PSC_W-1:0] p,
                                   input integer b);
    // Constant-width loop: a part-select with a variable bound is not legal
    psc_tap = 1'b1;
    for (int i = 0; i < `SPW_PSC_W; i++) begin
      if (i <= b) begin
        psc_tap = psc_tap & p[i];
      end
    end
  endfunction

  function automatic logic sel_tick(input logic [3:0] s,
                                    input logic [`SPW_PSC_W-1:0] p,
                                    input logic ev);
    case (s)
      `SPW_SEL_DIV1: sel_tick = 1'b1;
      `SPW_SEL_DIV2: sel_tick = psc_tap(p, `SPW_TAP_DIV2);
      `SPW_SEL_DIV4: sel_tick = psc_tap(p, `SPW_TAP_DIV4);
      `SPW_SEL_DIV8: sel_tick = psc_tap(p, `SPW_TAP_DIV8);
      `SPW_SEL_DIV64: sel_tick = psc_tap(p, `SPW_TAP_DIV64);
      `SPW_SEL_DIV256: sel_tick = psc_tap(p, `SPW_TAP_DIV256);
      `SPW_SEL_DIV1024: sel_tick = psc_tap(p, `SPW_TAP_DIV1024);
      default: sel_tick = s[3] & ev;
    endcase
  endfunction

  // Split form only exists when selected and a clock is picked
  always_comb begin
    case (run_reg)
      SPW_ST_OFF: run_next = (split_mode && clk_sel != `SPW_SEL_OFF) ?
                             SPW_ST_RUN : SPW_ST_OFF;
      SPW_ST_RUN: run_next = (split_mode && clk_sel != `SPW_SEL_OFF) ?
                             SPW_ST_RUN : SPW_ST_OFF;
      default: run_next = SPW_ST_OFF;
    endcase
  end

  assign run = (run_reg == SPW_ST_RUN) && split_mode &&
               (clk_sel != `SPW_SEL_OFF);

  // Prescaler free-runs only while counting so phase restarts cleanly
  always_comb begin
    psc_next = run ? psc_reg + `SPW_PSC_ONE : `SPW_PSC_RESET;
  end

  assign tick = run && sel_tick(clk_sel, psc_reg, evt_chan[evt_sel]);

  spw_half u_low (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .run(run),
    .tick(tick),
    .cfg(low_cfg),
    .st(low_st)
  );

  spw_half u_high (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .run(run),
    .tick(tick),
    .cfg(high_cfg),
    .st(high_st)
  );

  // Flags come from the low counter only; set beats acknowledge
  always_comb begin
    evt_next = (tick ? low_st.match : 4'h0);
    flag_next = (flag_reg & ~cmp_ack) | evt_next;
    unf_next = tick ? {high_st.bottom, low_st.bottom} : 2'b00;
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_next[i] = low_cfg.cmp_en[i] ?
                    (low_st.wave[i] ^ port_inv[i]) : port_out[i];
      pin_next[i+4] = high_cfg.cmp_en[i] ?
                    (high_st.wave[i] ^ port_inv[i+4]) : port_out[i+4];
    end
  end

  // Hi-res phase: a sub-step marker; the fast clock itself lives outside
  always_comb begin
    hr_next = (run && hires_sel != `SPW_HIRES_OFF) ?
              hr_reg + 2'h1 : `SPW_HIRES_OFF;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_reg <= SPW_ST_OFF;
      psc_reg <= `SPW_PSC_RESET;
      flag_reg <= 4'h0;
      evt_reg <= 4'h0;
      unf_reg <= 2'b00;
      pin_reg <= 8'h00;
      hr_reg <= `SPW_HIRES_OFF;
    end else if (ce) begin
      run_reg <= run_next;
      psc_reg <= psc_next;
      flag_reg <= flag_next;
      evt_reg <= evt_next;
      unf_reg <= unf_next;
      pin_reg <= pin_next;
      hr_reg <= hr_next;
    end
  end

  assign pin_out = pin_reg;
  assign waveform_output = {high_st.wave, low_st.wave};
  assign cmp_flag = flag_reg;
  assign cmp_event = evt_reg;
  assign cmp_dma_req = flag_reg;
  assign low_unf_event = unf_reg[0];
  assign high_unf_event = unf_reg[1];
  assign low_cnt = low_st.cnt;
  assign high_cnt = high_st.cnt;
  assign hires_phase = hr_reg;
  assign running = (run_reg == SPW_ST_RUN);

  property p_off_stops;
    @(posedge clk) disable iff (!resetn)
      (ce && clk_sel == `SPW_SEL_OFF) |=> $stable(low_cnt) &&
                                          $stable(high_cnt);
  endproperty
  a_off_stops: assert property (p_off_stops)
    else $error("counter moved with clock off");

  property p_down;
    @(posedge clk) disable iff (!resetn)
      (ce && tick && low_cnt != 8'h00) |=> low_cnt == $past(low_cnt) - 8'h01;
  endproperty
  a_down: assert property (p_down)
    else $error("low counter did not count down");

  property p_reload;
    @(posedge clk) disable iff (!resetn)
      (ce && tick && high_cnt == 8'h00) |=> high_cnt == $past(high_cfg.per);
  endproperty
  a_reload: assert property (p_reload)
    else $error("period not loaded at zero");

  property p_clear;
    @(posedge clk) disable iff (!resetn)
      (ce && tick && low_cnt == 8'h00) |=> waveform_output[3:0] == 4'h0;
  endproperty
  a_clear: assert property (p_clear)
    else $error("waveform not cleared at bottom");

  property p_set;
    @(posedge clk) disable iff (!resetn)
      (ce && tick && low_cnt != 8'h00 && low_cnt == low_cfg.cmp_a)
        |=> waveform_output[0];
  endproperty
  a_set: assert property (p_set)
    else $error("waveform not set on match");

  property p_flag;
    @(posedge clk) disable iff (!resetn)
      (ce && tick && low_cnt == low_cfg.cmp_b) |=> cmp_flag[1] && cmp_event[1];
  endproperty
  a_flag: assert property (p_flag)
    else $error("compare flag not raised");

  property p_no_spur;
    @(posedge clk) disable iff (!resetn)
      (ce && !tick) |=> cmp_event == 4'h0;
  endproperty
  a_no_spur: assert property (p_no_spur)
    else $error("compare event without count clock");

  property p_pin;
    @(posedge clk) disable iff (!resetn)
      (ce && high_cfg.cmp_en[0]) |=> pin_out[4] ==
        ($past(high_st.wave[0]) ^ $past(port_inv[4]));
  endproperty
  a_pin: assert property (p_pin)
    else $error("high pin not overridden");

  property p_normal;
    @(posedge clk) disable iff (!resetn)
      (ce && !split_mode) |=> !running;
  endproperty
  a_normal: assert property (p_normal)
    else $error("split form running in normal mode");
endmodule
`default_nettype wire

// [dv/spw_pin_model.sv]
`timescale 1ns/1ns
`default_nettype none

module spw_pin_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] pin,
  output var logic [7:0] seen_high
);
  logic [7:0] last;

  // Pins only listen; nothing is driven back into the timer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last <= 8'h00;
      seen_high <= 8'h00;
    end else begin
      last <= pin;
      seen_high <= seen_high | (pin & ~last);
    end
  end
endmodule

`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "spw_consts.svh"

module testbench;
  logic clk, resetn, ce, split_mode, low_unf, high_unf, running;
  logic [3:0] clk_sel, cmp_ack, cmp_flag, cmp_event, cmp_dma_req;
  logic [`SPW_EVT_W-1:0] evt_sel;
  logic [(1<<`SPW_EVT_W)-1:0] evt_chan;
  logic [`SPW_HIRES_W-1:0] hires_sel, hires_phase;
  logic [7:0] port_out, port_inv, pin_out, wave, low_cnt, high_cnt, seen;
  spw_pkg::spw_half_cfg_s low_cfg, high_cfg;
  int n_mismatch = 0;
  int samples_checked = 0;

  spw_timer DUT (.clk(clk), .resetn(resetn), .ce(ce),
    .split_mode(split_mode), .clk_sel(clk_sel), .evt_sel(evt_sel),
    .evt_chan(evt_chan), .hires_sel(hires_sel), .low_cfg(low_cfg),
    .high_cfg(high_cfg), .port_out(port_out), .port_inv(port_inv),
    .cmp_ack(cmp_ack), .pin_out(pin_out), .waveform_output(wave),
    .cmp_flag(cmp_flag), .cmp_event(cmp_event),
    .cmp_dma_req(cmp_dma_req), .low_unf_event(low_unf),
    .high_unf_event(high_unf), .low_cnt(low_cnt), .high_cnt(high_cnt),
    .hires_phase(hires_phase), .running(running));

  spw_pin_model PINS (.clk(clk), .resetn(resetn), .pin(pin_out),
    .seen_high(seen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cmpv(input logic [15:0] got, exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Sample just after the edge so the design's updates have landed
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_cnt(input bit hi, input logic [7:0] v);
    int i;
    i = 0;
    while ((hi ? high_cnt : low_cnt) !== v && i < 3000) begin
      tk(1);
      i++;
    end
    cmpv(hi ? high_cnt : low_cnt, v, "wait count");
  endtask

  task automatic gap(output int n);
    logic [7:0] c;
    c = low_cnt;
    n = 0;
    while (low_cnt === c && n < 2100) begin
      tk(1);
      n++;
    end
  endtask

  task automatic t_off;
    @(posedge clk);
    split_mode <= 1'b1;
    // Fields: per, cmp_d, cmp_c, cmp_b, cmp_a, cmp_en
    low_cfg <= {8'h05, 8'hf0, 8'hf0, 8'h04, 8'h03, 4'hf};
    high_cfg <= {8'h07, 8'h05, 8'h04, 8'h03, 8'h02, 4'hf};
    tk(20);
    cmpv({low_cnt, 7'h00, running}, 16'h0000, "off");
    @(posedge clk);
    split_mode <= 1'b0;
    clk_sel <= 4'h1;
    tk(20);
    cmpv({high_cnt, 7'h00, running}, 16'h0000, "normal");
    @(posedge clk);
    split_mode <= 1'b1;
    tk(2);
    cmpv(running, 1, "run");
  endtask

  task automatic t_pwm;
    int k;
    logic [7:0] pw;
    logic [1:0] hp;
    wait_cnt(0, 8'h05);
    for (k = 4; k >= 0; k--) begin
      tk(1);
      cmpv(low_cnt, k, "down");
      if (k == 2) begin
        cmpv(wave[0], 1, "set");
        cmpv({cmp_event, cmp_flag}, 8'h13, "flag");
      end
    end
    tk(1);
    cmpv({low_cnt, wave[0], low_unf}, {8'h05, 2'b01}, "reload");
    wait_cnt(1, 8'h07);
    for (k = 6; k >= 0; k--) begin
      tk(1);
      cmpv(high_cnt, k, "high down");
    end
    tk(1);
    cmpv(high_cnt, 8'h07, "high reload");
    cmpv(seen[7:4], 4'hf, "high pins");
    wait_cnt(0, 8'h05);
    // Channel B matches on the same edge as its clear, so its set wins
    @(posedge clk);
    cmp_ack <= 4'h3;
    @(posedge clk);
    cmp_ack <= 4'h0;
    #1;
    cmpv({cmp_dma_req, cmp_flag}, 8'h22, "ack");
    @(posedge clk);
    port_inv <= 8'h0f;
    port_out <= 8'ha5;
    tk(3);
    pw = wave;
    tk(1);
    cmpv(pin_out, pw ^ 8'h0f, "pins");
    @(posedge clk);
    low_cfg.cmp_en <= 4'h0;
    tk(3);
    cmpv(pin_out[3:0], 4'h5, "port");
    @(posedge clk);
    hires_sel <= 2'h1;
    tk(3);
    hp = hires_phase;
    tk(1);
    cmpv(hires_phase, 2'(hp + 2'h1), "hires step");
  endtask

  task automatic t_presc;
    int s, g;
    int dv[7] = '{1, 2, 4, 8, 64, 256, 1024};
    logic [7:0] c;
    for (s = 0; s < 7; s++) begin
      @(posedge clk);
      clk_sel <= 4'(s + 1);
      gap(g);
      gap(g);
      gap(g);
      cmpv(g[15:0], dv[s][15:0], "divide");
    end
    @(posedge clk);
    evt_sel <= 3'h3;
    for (s = 8; s < 16; s++) begin
      @(posedge clk);
      clk_sel <= 4'(s);
      tk(3);
      c = low_cnt;
      @(posedge clk);
      evt_chan <= 8'h20;
      @(posedge clk);
      evt_chan <= 8'h08;
      @(posedge clk);
      evt_chan <= 8'h00;
      tk(3);
      cmpv(low_cnt, (c == 8'h00) ? 8'h05 : c - 8'h01, "event");
    end
  endtask

  // Prescaler sweep dominates the run at up to about 4100 cycles
  initial begin
    #100000;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    give_verdict;
  end

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    split_mode = 1'b0;
    clk_sel = 4'h0;
    evt_sel = 3'h0;
    evt_chan = 8'h00;
    hires_sel = 2'h0;
    low_cfg = '0;
    high_cfg = '0;
    port_out = 8'h00;
    port_inv = 8'h00;
    cmp_ack = 4'h0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    tk(1);
    cmpv({low_cnt, high_cnt}, 16'h0000, "reset");
    t_off;
    t_pwm;
    t_presc;
    give_verdict;
  end
endmodule

`default_nettype wire
